// ===== rtl/lesr_link_event_and_selfid_regs.sv
// Topology status, channel enable and interrupt event registers of the link controller.
`timescale 1ns/10ps
`default_nettype none

module lesr_link_event_and_selfid_regs #(
  parameter int OVERRUN_CYCLES = lesr_pkg::OVERRUN_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Topology capture
  input wire logic bus_reinit_event,
  input wire logic capture_quadlet,
  input wire logic capture_done,
  input wire logic capture_fault,
  // Cycle timing
  input wire logic [31:0] local_cycle_timer,
  input wire logic cycle_begin_signal,
  input wire logic rx_cycle_start,
  input wire logic [31:0] rx_cycle_time,
  input wire logic timer_host_write,
  input wire logic [31:0] timer_write_data,
  input wire logic subaction_gap,
  input wire logic cycle_master_request,
  // Other event sources
  input wire logic link_reg_byte_arrived,
  input wire logic link_status_irq,
  input wire logic halt_error,
  input wire logic [31:0] dma_sources,
  input wire logic [31:0] context_halted_flag,
  input wire logic [31:0] iso_tx_sources,
  input wire logic [31:0] iso_rx_sources,
  // Outputs
  output logic [63:0] channel_enable_bits,
  output logic cycle_master_role,
  output logic irq
);

  // ==========================================================================
  // Write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
    hit = w && (a == ofs);
  endfunction

  function automatic logic [31:0] rises(input logic [31:0] now, input logic [31:0] prev);
    rises = now & ~prev;
  endfunction

  logic [31:0] event_flags, event_enables;
  logic [31:0] iso_tx_event, iso_tx_mask, iso_rx_event, iso_rx_mask;
  logic [31:0] src_prev, iso_tx_prev, iso_rx_prev;
  logic [31:0] src_now, src_rise, ev_view, ev_clr, ev_set, next_event_flags;
  logic [31:0] topology_buffer_base_field;
  logic topology_error_flag;
  logic [7:0] topology_generation_counter;
  logic [lesr_pkg::SIZE_W-1:0] topology_size_field;
  logic seen_start, bus_rise, overrun_fire, iso_tx_summary, iso_rx_summary, count_prev, sec_prev;
  logic [15:0] ov_count;
  lesr_pkg::lesr_ov_state_t ov_state;

  assign bus_rise = src_rise[lesr_pkg::EV_BUS_REINIT];
  assign iso_tx_summary = |(iso_tx_event & iso_tx_mask);
  assign iso_rx_summary = |(iso_rx_event & iso_rx_mask);

  // ==========================================================================
  // Event sources, gathered as levels so that only edges set flags
  always_comb begin
    src_now = dma_sources & lesr_pkg::EV_DMA_BITS;
    // Halted contexts may not raise ordinary events while the halt flag stands.
    if (event_flags[lesr_pkg::EV_HALT]) begin
      src_now = src_now & ~context_halted_flag;
    end
    src_now[lesr_pkg::EV_REG_BYTE] = link_reg_byte_arrived;
    src_now[lesr_pkg::EV_OVERRUN] = overrun_fire;
    src_now[lesr_pkg::EV_HALT] = halt_error;
    src_now[lesr_pkg::EV_MISMATCH] = (rx_cycle_start && (rx_cycle_time[31:12]
      != local_cycle_timer[31:12])) || (timer_host_write
      && (timer_write_data[31:12] != local_cycle_timer[31:12]));
    src_now[lesr_pkg::EV_MISSED] = (local_cycle_timer[lesr_pkg::TIMER_COUNT_LSB]
      != count_prev) && !seen_start;
    src_now[lesr_pkg::EV_SEC64] = local_cycle_timer[lesr_pkg::TIMER_SEC_BIT6]
      != sec_prev;
    src_now[lesr_pkg::EV_NEW_CYCLE] = local_cycle_timer[lesr_pkg::TIMER_COUNT_LSB]
      != count_prev;
    src_now[lesr_pkg::EV_LINK_IRQ] = link_status_irq;
    src_now[lesr_pkg::EV_BUS_REINIT] = bus_reinit_event;
    src_now[lesr_pkg::EV_CAPTURE_DONE] = capture_done;
    src_rise = rises(src_now, src_prev);
  end

  // Timer bits are compared against their own last value, so each toggle is one event.
  always_ff @(posedge clock) begin
    if (rst) begin
      src_prev <= lesr_pkg::ZERO_RESET;
      iso_tx_prev <= lesr_pkg::ZERO_RESET;
      iso_rx_prev <= lesr_pkg::ZERO_RESET;
      count_prev <= 1'b0;
      sec_prev <= 1'b0;
    end else begin
      src_prev <= src_now;
      iso_tx_prev <= iso_tx_sources;
      iso_rx_prev <= iso_rx_sources;
      count_prev <= local_cycle_timer[lesr_pkg::TIMER_COUNT_LSB];
      sec_prev <= local_cycle_timer[lesr_pkg::TIMER_SEC_BIT6];
    end
  end

  // ==========================================================================
  // Missed cycle start tracking
  always_ff @(posedge clock) begin
    if (rst) begin
      seen_start <= 1'b0;
    end else if (cycle_begin_signal || rx_cycle_start) begin
      seen_start <= 1'b1;
    end else if (local_cycle_timer[lesr_pkg::TIMER_COUNT_LSB] != count_prev) begin
      seen_start <= 1'b0;
    end
  end

  // ==========================================================================
  // Cycle overrun timer
  always_ff @(posedge clock) begin
    if (rst) begin
      ov_state <= lesr_pkg::LESR_OV_IDLE;
      ov_count <= 16'h0000;
      overrun_fire <= 1'b0;
    end else begin
      overrun_fire <= 1'b0;
      case (ov_state)
        lesr_pkg::LESR_OV_IDLE: begin
          ov_count <= 16'h0000;
          if (cycle_begin_signal && cycle_master_role) begin
            ov_state <= lesr_pkg::LESR_OV_TIMING;
          end
        end
        default: begin
          if (subaction_gap || bus_reinit_event || !cycle_master_role) begin
            ov_state <= lesr_pkg::LESR_OV_IDLE;
          end else if (ov_count == 16'(OVERRUN_CYCLES - 1)) begin
            overrun_fire <= 1'b1;
            ov_state <= lesr_pkg::LESR_OV_IDLE;
          end else begin
            ov_count <= ov_count + 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cycle_master_role <= 1'b0;
    end else if (overrun_fire) begin
      cycle_master_role <= 1'b0;
    end else if (cycle_master_request) begin
      cycle_master_role <= 1'b1;
    end
  end

  // ==========================================================================
  // Topology capture status
  always_ff @(posedge clock) begin
    if (rst) begin
      topology_buffer_base_field <= lesr_pkg::ZERO_RESET;
    end else if (hit(reg_addr, lesr_pkg::OFS_TOPO_BASE, reg_wr)) begin
      topology_buffer_base_field <= {reg_wdata[31:lesr_pkg::BASE_LSB],
        11'h000};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      topology_generation_counter <= 8'h00;
      topology_size_field <= 11'h000;
      topology_error_flag <= 1'b0;
    end else begin
      if (bus_rise) begin
        topology_generation_counter <= topology_generation_counter + 8'h01;
        topology_size_field <= 11'h000;
      end else if (capture_quadlet) begin
        topology_size_field <= topology_size_field + 11'h001;
      end
      if (capture_done) begin
        topology_error_flag <= capture_fault;
      end
    end
  end

  // ==========================================================================
  // Channel enables keep their contents across every kind of reset.
  always_ff @(posedge clock) begin
    if (hit(reg_addr, lesr_pkg::OFS_CHAN_HIGH_SET, reg_wr)) begin
      channel_enable_bits[63:32] <= channel_enable_bits[63:32] | reg_wdata;
    end else if (hit(reg_addr, lesr_pkg::OFS_CHAN_HIGH_CLR, reg_wr)) begin
      channel_enable_bits[63:32] <= channel_enable_bits[63:32] & ~reg_wdata;
    end
    if (hit(reg_addr, lesr_pkg::OFS_CHAN_LOW_SET, reg_wr)) begin
      channel_enable_bits[31:0] <= channel_enable_bits[31:0] | reg_wdata;
    end else if (hit(reg_addr, lesr_pkg::OFS_CHAN_LOW_CLR, reg_wr)) begin
      channel_enable_bits[31:0] <= channel_enable_bits[31:0] & ~reg_wdata;
    end
  end

  // ==========================================================================
  // Primary event and enable registers; hardware set wins over software clear.
  always_comb begin
    ev_clr = hit(reg_addr, lesr_pkg::OFS_EVENT_CLR, reg_wr) ? reg_wdata : 32'h0000_0000;
    ev_set = hit(reg_addr, lesr_pkg::OFS_EVENT_SET, reg_wr) ? reg_wdata : 32'h0000_0000;
    ev_set = (ev_set | src_rise) & lesr_pkg::EV_WRITABLE;
    if (bus_rise) begin
      ev_clr[lesr_pkg::EV_CAPTURE_DONE] = 1'b1;
      ev_set[lesr_pkg::EV_CAPTURE_DONE] = 1'b0;
    end
    next_event_flags = (event_flags & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      event_flags <= lesr_pkg::ZERO_RESET;
    end else begin
      event_flags <= next_event_flags;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      event_enables <= lesr_pkg::ZERO_RESET;
    end else if (hit(reg_addr, lesr_pkg::OFS_ENABLE_SET, reg_wr)) begin
      event_enables <= event_enables | (reg_wdata & lesr_pkg::EN_WRITABLE);
    end else if (hit(reg_addr, lesr_pkg::OFS_ENABLE_CLR, reg_wr)) begin
      event_enables <= event_enables & ~reg_wdata;
    end
  end

  // ==========================================================================
  // Secondary iso context registers
  always_ff @(posedge clock) begin
    if (rst) begin
      iso_tx_event <= lesr_pkg::ZERO_RESET;
      iso_rx_event <= lesr_pkg::ZERO_RESET;
      iso_tx_mask <= lesr_pkg::ZERO_RESET;
      iso_rx_mask <= lesr_pkg::ZERO_RESET;
    end else begin
      iso_tx_event <= (iso_tx_event
        & ~(hit(reg_addr, lesr_pkg::OFS_ISO_TX_EVENT_CLR, reg_wr) ? reg_wdata : 32'h0))
        | (hit(reg_addr, lesr_pkg::OFS_ISO_TX_EVENT_SET, reg_wr) ? reg_wdata : 32'h0)
        | rises(iso_tx_sources, iso_tx_prev);
      iso_rx_event <= (iso_rx_event
        & ~(hit(reg_addr, lesr_pkg::OFS_ISO_RX_EVENT_CLR, reg_wr) ? reg_wdata : 32'h0))
        | (hit(reg_addr, lesr_pkg::OFS_ISO_RX_EVENT_SET, reg_wr) ? reg_wdata : 32'h0)
        | rises(iso_rx_sources, iso_rx_prev);
      iso_tx_mask <= (iso_tx_mask
        & ~(hit(reg_addr, lesr_pkg::OFS_ISO_TX_MASK_CLR, reg_wr) ? reg_wdata : 32'h0))
        | (hit(reg_addr, lesr_pkg::OFS_ISO_TX_MASK_SET, reg_wr) ? reg_wdata : 32'h0);
      iso_rx_mask <= (iso_rx_mask
        & ~(hit(reg_addr, lesr_pkg::OFS_ISO_RX_MASK_CLR, reg_wr) ? reg_wdata : 32'h0))
        | (hit(reg_addr, lesr_pkg::OFS_ISO_RX_MASK_SET, reg_wr) ? reg_wdata : 32'h0);
    end
  end

  // ==========================================================================
  // Interrupt request and read-back
  always_comb begin
    ev_view = event_flags;
    ev_view[lesr_pkg::EV_ISO_RX] = iso_rx_summary;
    ev_view[lesr_pkg::EV_ISO_TX] = iso_tx_summary;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= event_enables[lesr_pkg::GATE_BIT] && |(ev_view & event_enables);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= lesr_pkg::ZERO_RESET;
    end else if (reg_rd) begin
      if (reg_addr == lesr_pkg::OFS_TOPO_BASE) begin
        reg_rdata <= topology_buffer_base_field;
      end else if (reg_addr == lesr_pkg::OFS_TOPO_STATUS) begin
        reg_rdata <= {topology_error_flag, 7'h00, topology_generation_counter, 3'h0,
          topology_size_field, 2'h0};
      end else if (reg_addr == lesr_pkg::OFS_CHAN_HIGH_SET
          || reg_addr == lesr_pkg::OFS_CHAN_HIGH_CLR) begin
        reg_rdata <= channel_enable_bits[63:32];
      end else if (reg_addr == lesr_pkg::OFS_CHAN_LOW_SET
          || reg_addr == lesr_pkg::OFS_CHAN_LOW_CLR) begin
        reg_rdata <= channel_enable_bits[31:0];
      end else if (reg_addr == lesr_pkg::OFS_EVENT_SET) begin
        reg_rdata <= ev_view;
      end else if (reg_addr == lesr_pkg::OFS_EVENT_CLR) begin
        reg_rdata <= ev_view & event_enables;
      end else if (reg_addr == lesr_pkg::OFS_ENABLE_SET
          || reg_addr == lesr_pkg::OFS_ENABLE_CLR) begin
        reg_rdata <= event_enables;
      end else if (reg_addr == lesr_pkg::OFS_ISO_TX_EVENT_SET) begin
        reg_rdata <= iso_tx_event;
      end else if (reg_addr == lesr_pkg::OFS_ISO_TX_EVENT_CLR) begin
        reg_rdata <= iso_tx_event & iso_tx_mask;
      end else if (reg_addr == lesr_pkg::OFS_ISO_TX_MASK_SET
          || reg_addr == lesr_pkg::OFS_ISO_TX_MASK_CLR) begin
        reg_rdata <= iso_tx_mask;
      end else if (reg_addr == lesr_pkg::OFS_ISO_RX_EVENT_SET) begin
        reg_rdata <= iso_rx_event;
      end else if (reg_addr == lesr_pkg::OFS_ISO_RX_EVENT_CLR) begin
        reg_rdata <= iso_rx_event & iso_rx_mask;
      end else if (reg_addr == lesr_pkg::OFS_ISO_RX_MASK_SET
          || reg_addr == lesr_pkg::OFS_ISO_RX_MASK_CLR) begin
        reg_rdata <= iso_rx_mask;
      end else begin
        reg_rdata <= lesr_pkg::ZERO_RESET;
      end
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_bus_reset;
    bus_rise ##1 1'b1;
  endsequence
  property p_irq_follows;
    @(posedge clock) disable iff (rst)
      (event_enables[31] && |(ev_view & event_enables)) |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missed");
  property p_gate_blocks;
    @(posedge clock) disable iff (rst) !event_enables[31] |=> !irq;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("irq with gate off");
  property p_gen_step;
    @(posedge clock) disable iff (rst)
      bus_rise |=> topology_generation_counter == $past(topology_generation_counter) + 8'h01;
  endproperty
  a_gen_step: assert property (p_gen_step) else $error("generation not stepped");
  property p_size_cleared;
    @(posedge clock) disable iff (rst) s_bus_reset |-> topology_size_field == 11'h000;
  endproperty
  a_size_cleared: assert property (p_size_cleared) else $error("size not cleared");
  property p_complete_dropped;
    @(posedge clock) disable iff (rst) s_bus_reset |-> event_flags[17] && !event_flags[16];
  endproperty
  a_complete_dropped: assert property (p_complete_dropped) else $error("bit 16 kept");
  property p_new_cycle_edge;
    @(posedge clock) disable iff (rst)
      $changed(local_cycle_timer[12]) && !src_prev[20] |=> event_flags[20];
  endproperty
  a_new_cycle_edge: assert property (p_new_cycle_edge) else $error("cycle event lost");
  property p_overrun;
    @(posedge clock) disable iff (rst)
      overrun_fire |=> !cycle_master_role && event_flags[25];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");
  property p_masked_read;
    @(posedge clock) disable iff (rst)
      reg_rd && reg_addr == 8'h84 |=> reg_rdata == $past(ev_view & event_enables);
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked read wrong");
  property p_base_low_zero;
    @(posedge clock) disable iff (rst) topology_buffer_base_field[10:0] == 11'h000;
  endproperty
  a_base_low_zero: assert property (p_base_low_zero) else $error("base low bits set");

endmodule

`default_nettype wire

// ===== rtl/lesr_pkg.sv
// Constants shared by the link event and topology status block.
package lesr_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_TOPO_BASE = 8'h64;
  localparam logic [7:0] OFS_TOPO_STATUS = 8'h68;
  localparam logic [7:0] OFS_CHAN_HIGH_SET = 8'h70;
  localparam logic [7:0] OFS_CHAN_HIGH_CLR = 8'h74;
  localparam logic [7:0] OFS_CHAN_LOW_SET = 8'h78;
  localparam logic [7:0] OFS_CHAN_LOW_CLR = 8'h7c;
  localparam logic [7:0] OFS_EVENT_SET = 8'h80;
  localparam logic [7:0] OFS_EVENT_CLR = 8'h84;
  localparam logic [7:0] OFS_ENABLE_SET = 8'h88;
  localparam logic [7:0] OFS_ENABLE_CLR = 8'h8c;
  localparam logic [7:0] OFS_ISO_TX_EVENT_SET = 8'h90;
  localparam logic [7:0] OFS_ISO_TX_EVENT_CLR = 8'h94;
  localparam logic [7:0] OFS_ISO_TX_MASK_SET = 8'h98;
  localparam logic [7:0] OFS_ISO_TX_MASK_CLR = 8'h9c;
  localparam logic [7:0] OFS_ISO_RX_EVENT_SET = 8'ha0;
  localparam logic [7:0] OFS_ISO_RX_EVENT_CLR = 8'ha4;
  localparam logic [7:0] OFS_ISO_RX_MASK_SET = 8'ha8;
  localparam logic [7:0] OFS_ISO_RX_MASK_CLR = 8'hac;
  // ==========================================================================
  // Field positions
  localparam int BASE_LSB = 11;
  localparam int ERROR_BIT = 31;
  localparam int GEN_LSB = 16;
  localparam int SIZE_LSB = 2;
  localparam int SIZE_W = 11;
  localparam int EV_REG_BYTE = 26;
  localparam int EV_OVERRUN = 25;
  localparam int EV_HALT = 24;
  localparam int EV_MISMATCH = 23;
  localparam int EV_MISSED = 22;
  localparam int EV_SEC64 = 21;
  localparam int EV_NEW_CYCLE = 20;
  localparam int EV_LINK_IRQ = 19;
  localparam int EV_BUS_REINIT = 17;
  localparam int EV_CAPTURE_DONE = 16;
  localparam int EV_ISO_RX = 7;
  localparam int EV_ISO_TX = 6;
  localparam int GATE_BIT = 31;
  localparam int TIMER_SEC_BIT6 = 31;
  localparam int TIMER_COUNT_LSB = 12;
  localparam int TIMER_COUNT_MSB = 24;
  localparam int TIMER_SEC_MSB = 31;
  // ==========================================================================
  // Writable bits and reset values
  localparam logic [31:0] EV_WRITABLE = 32'h07fb_033f;
  localparam logic [31:0] EV_DMA_BITS = 32'h0000_033f;
  localparam logic [31:0] EN_WRITABLE = 32'h87fb_03ff;
  localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
  // ==========================================================================
  // Timing
  localparam int CLOCK_MHZ = 100;
  localparam int OVERRUN_MIN_US = 115;
  localparam int OVERRUN_CYCLES = OVERRUN_MIN_US * CLOCK_MHZ;
  typedef enum logic [0:0] {LESR_OV_IDLE = 1'b0, LESR_OV_TIMING = 1'b1} lesr_ov_state_t;
endpackage

// ===== sim/tb.sv
// Self-checking bench for the link event and topology status block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ==========================================================================
  // Stimulus and observed signals
  localparam int OVR = 20;
  logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, local_cycle_timer = 32'h0, rx_cycle_time = 32'h0;
  logic bus_reinit_event = 1'b0, capture_quadlet = 1'b0, capture_done = 1'b0;
  logic capture_fault = 1'b0, cycle_begin_signal = 1'b0, rx_cycle_start = 1'b0;
  logic timer_host_write = 1'b0, subaction_gap = 1'b0, cycle_master_request = 1'b0;
  logic link_reg_byte_arrived = 1'b0, link_status_irq = 1'b0, halt_error = 1'b0;
  logic [31:0] timer_write_data = 32'h0, dma_sources = 32'h0, context_halted_flag = 32'h0;
  logic [31:0] iso_tx_sources = 32'h0, iso_rx_sources = 32'h0;
  logic [63:0] channel_enable_bits;
  logic cycle_master_role, irq;
  int failures = 0, total_checks = 0, cycles = 0;
  lesr_link_event_and_selfid_regs #(.OVERRUN_CYCLES(OVR)) dut (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .bus_reinit_event(bus_reinit_event),
    .capture_quadlet(capture_quadlet), .capture_done(capture_done),
    .capture_fault(capture_fault), .local_cycle_timer(local_cycle_timer),
    .cycle_begin_signal(cycle_begin_signal), .rx_cycle_start(rx_cycle_start),
    .rx_cycle_time(rx_cycle_time), .timer_host_write(timer_host_write),
    .timer_write_data(timer_write_data), .subaction_gap(subaction_gap),
    .cycle_master_request(cycle_master_request), .link_reg_byte_arrived(link_reg_byte_arrived),
    .link_status_irq(link_status_irq), .halt_error(halt_error), .dma_sources(dma_sources),
    .context_halted_flag(context_halted_flag), .iso_tx_sources(iso_tx_sources),
    .iso_rx_sources(iso_rx_sources), .channel_enable_bits(channel_enable_bits),
    .cycle_master_role(cycle_master_role), .irq(irq));
  always #5 clock = ~clock;
  // ==========================================================================
  // Access tasks
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic chkr(input string what, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(what, {32'h0, exp}, {32'h0, reg_rdata & m});
  endtask
  // Waits for the edge to land, checks the raw flags, then clears them all.
  task automatic ev(input string what, input logic [31:0] m, input logic [31:0] exp);
    repeat (2) @(posedge clock);
    chkr(what, lesr_pkg::OFS_EVENT_SET, m, exp);
    wr(lesr_pkg::OFS_EVENT_CLR, 32'hffff_ffff);
  endtask
  task automatic bus_reset;
    @(posedge clock);
    bus_reinit_event <= 1'b1;
    @(posedge clock);
    bus_reinit_event <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the longest expected run.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end
  // ==========================================================================
  // Test sequence
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Channel enables have no reset value, so they are cleared before any check.
    wr(lesr_pkg::OFS_CHAN_HIGH_CLR, 32'hffff_ffff);
    wr(lesr_pkg::OFS_CHAN_LOW_CLR, 32'hffff_ffff);
    wr(lesr_pkg::OFS_TOPO_BASE, 32'hffff_ffff);
    chkr("base", lesr_pkg::OFS_TOPO_BASE, '1, 32'hffff_f800);
    wr(lesr_pkg::OFS_CHAN_HIGH_SET, 32'ha5a5_a5a5);
    wr(lesr_pkg::OFS_CHAN_HIGH_CLR, 32'h0000_ffff);
    wr(lesr_pkg::OFS_CHAN_LOW_SET, 32'h1234_5678);
    wr(lesr_pkg::OFS_CHAN_LOW_CLR, 32'hffff_0000);
    bus_reset();
    chkr("chan_high", lesr_pkg::OFS_CHAN_HIGH_SET, '1, 32'ha5a5_0000);
    chkr("chan_low", lesr_pkg::OFS_CHAN_LOW_CLR, '1, 32'h0000_5678);
    chk("chan_bits", 64'ha5a5_0000_0000_5678, channel_enable_bits);
    $display("test channels done");
    repeat (3) begin
      @(posedge clock);
      capture_quadlet <= 1'b1;
      @(posedge clock);
      capture_quadlet <= 1'b0;
    end
    capture_done <= 1'b1;
    capture_fault <= 1'b1;
    @(posedge clock);
    capture_done <= 1'b0;
    chkr("status_fault", lesr_pkg::OFS_TOPO_STATUS, '1, 32'h8001_000c);
    @(posedge clock);
    capture_fault <= 1'b0;
    capture_done <= 1'b1;
    @(posedge clock);
    capture_done <= 1'b0;
    chkr("status_clean", lesr_pkg::OFS_TOPO_STATUS, '1, 32'h0001_000c);
    bus_reset();
    chkr("status_reset", lesr_pkg::OFS_TOPO_STATUS, '1, 32'h0002_0000);
    repeat (254) bus_reset();
    chkr("status_wrap", lesr_pkg::OFS_TOPO_STATUS, '1, 32'h0000_0000);
    $display("test topology done");
    wr(lesr_pkg::OFS_EVENT_CLR, 32'hffff_ffff);
    wr(lesr_pkg::OFS_EVENT_SET, 32'hffff_ffff);
    wr(lesr_pkg::OFS_ENABLE_SET, 32'h7fff_ffff);
    chkr("ev_raw", lesr_pkg::OFS_EVENT_SET, '1, lesr_pkg::EV_WRITABLE);
    chkr("ev_masked", lesr_pkg::OFS_EVENT_CLR, '1, lesr_pkg::EV_WRITABLE);
    chk("irq_gated", 64'h0, {63'h0, irq});
    wr(lesr_pkg::OFS_ENABLE_SET, 32'h8000_0000);
    #1 chk("irq_early", 64'h0, {63'h0, irq});
    @(posedge clock);
    #1 chk("irq_on", 64'h1, {63'h0, irq});
    wr(lesr_pkg::OFS_EVENT_CLR, lesr_pkg::EV_WRITABLE);
    @(posedge clock);
    #1 chk("irq_off", 64'h0, {63'h0, irq});
    $display("test interrupt done");
    @(posedge clock);
    link_status_irq <= 1'b1;
    ev("ev_link", '1, 32'h0008_0000);
    ev("ev_level", '1, 32'h0);
    link_reg_byte_arrived <= 1'b1;
    ev("ev_regbyte", '1, 32'h0400_0000);
    context_halted_flag <= 32'h2;
    halt_error <= 1'b1;
    repeat (2) @(posedge clock);
    dma_sources <= 32'h3;
    ev("ev_halt", '1, 32'h0100_0001);
    local_cycle_timer <= 32'h0000_1000;
    ev("ev_cycle", 32'h0010_0000, 32'h0010_0000);
    local_cycle_timer <= 32'h0000_0000;
    ev("ev_lost", 32'h0040_0000, 32'h0040_0000);
    local_cycle_timer <= 32'h8000_0000;
    ev("ev_sec64", 32'h0020_0000, 32'h0020_0000);
    timer_host_write <= 1'b1;
    timer_write_data <= 32'h0123_4000;
    @(posedge clock);
    timer_host_write <= 1'b0;
    ev("ev_twrite", 32'h0080_0000, 32'h0080_0000);
    rx_cycle_start <= 1'b1;
    rx_cycle_time <= 32'h4000_0000;
    @(posedge clock);
    rx_cycle_start <= 1'b0;
    ev("ev_rxtime", 32'h0080_0000, 32'h0080_0000);
    wr(lesr_pkg::OFS_EVENT_SET, 32'h0001_0000);
    bus_reset();
    ev("ev_bus_reinit_event", 32'h0003_0000, 32'h0002_0000);
    $display("test sources done");
    iso_rx_sources <= 32'h1;
    iso_tx_sources <= 32'h1;
    wr(lesr_pkg::OFS_ISO_RX_MASK_SET, 32'h1);
    chkr("iso_rx", lesr_pkg::OFS_EVENT_SET, 32'hc0, 32'h80);
    wr(lesr_pkg::OFS_ISO_TX_MASK_SET, 32'h1);
    chkr("iso_tx_ev", lesr_pkg::OFS_ISO_TX_EVENT_SET, '1, 32'h1);
    wr(lesr_pkg::OFS_ISO_RX_EVENT_CLR, 32'h1);
    chkr("iso_both", lesr_pkg::OFS_EVENT_SET, 32'hc0, 32'h40);
    @(posedge clock);
    cycle_master_request <= 1'b1;
    @(posedge clock);
    cycle_master_request <= 1'b0;
    cycle_begin_signal <= 1'b1;
    @(posedge clock);
    cycle_begin_signal <= 1'b0;
    repeat (OVR - 4) @(posedge clock);
    #1 chk("role_kept", 64'h1, {63'h0, cycle_master_role});
    repeat (10) @(posedge clock);
    #1 chk("role_dropped", 64'h0, {63'h0, cycle_master_role});
    ev("ev_overrun", 32'h0200_0000, 32'h0200_0000);
    // A subaction gap right after the cycle start must cancel the overrun timer.
    cycle_master_request <= 1'b1;
    @(posedge clock);
    cycle_master_request <= 1'b0;
    cycle_begin_signal <= 1'b1;
    @(posedge clock);
    cycle_begin_signal <= 1'b0;
    subaction_gap <= 1'b1;
    @(posedge clock);
    subaction_gap <= 1'b0;
    repeat (OVR + 5) @(posedge clock);
    #1 chk("role_gap", 64'h1, {63'h0, cycle_master_role});
    ev("ev_no_overrun", 32'h0200_0000, 32'h0);
    $display("test iso and overrun done");
    test_done();
  end
endmodule
`default_nettype wire
